// ==== down_timer_pkg.sv ====
package down_timer_pkg;
  // register byte offsets
  localparam logic [5:0] ctrl_a_off = 6'h00;
  localparam logic [5:0] ctrl_b_off = 6'h04;
  localparam logic [5:0] high_bits_off = 6'h08;
  localparam logic [5:0] reload_low_off = 6'h0c;
  localparam logic [5:0] duty_low_off = 6'h10;
  localparam logic [5:0] prescale_view_off = 6'h14;
  localparam logic [5:0] irq_flag_off = 6'h18;
  localparam logic [5:0] irq_enable_off = 6'h1c;
  localparam logic [5:0] buzzer_ctrl_off = 6'h20;
  // timer_ctrl_a fields
  localparam int pwm_out_en_bit = 7;
  localparam int pwm_active_low_bit = 6;
  localparam int one_shot_sel_bit = 2;
  localparam int reload_sel_bit = 1;
  localparam int timer_run_bit = 0;
  // timer_ctrl_b fields
  localparam int count_src_sel_bit = 5;
  localparam int ext_edge_sel_bit = 4;
  localparam int prescale_enable_n_bit = 3;
  localparam int prescale_ratio_lsb = 0;
  // high_bits_reg fields
  localparam int reload_hi_lsb = 4;
  localparam int duty_hi_lsb = 0;
  // interrupt fields
  localparam int underflow_flag_bit = 3;
  localparam int global_irq_en_bit = 7;
  // buzzer_ctrl_reg fields
  localparam int buzzer_en_bit = 7;
  localparam int buzzer_src_bit = 3;
  // reset values and constants
  localparam logic [7:0] ctrl_a_rst = 8'h00;
  localparam logic [7:0] ctrl_b_rst = 8'h08;
  localparam logic [7:0] buzzer_ctrl_rst = 8'h00;
  localparam logic [9:0] count_max = 10'h3ff;
  localparam logic [9:0] count_rst = 10'h3ff;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// ==== down_timer_pwm_buzzer.sv ====
// Notes on behaviour
// - ten-bit counter decrements on each prescaled tick
// - reload buffered; moved in on underflow while running
// - stopped timer loads reload on low byte write
// - reading reload low byte returns live count
// - counting only while timer_run is set
// - count_src_sel picks external pin or instruction clock
// - ext_edge_sel one counts falling, zero rising edges
// - prescaler divides 1:2..1:256 when enable_n low
// - prescaler count readable in read-only register
// - one-shot counts down once to zero, stops
// - continuous restarts from reload or 0x3ff
// - underflow sets flag; irq needs enable and global
// - underflow flag cleared only by software zero
// - pwm_out_en routes pwm, forces pin output
// - pwm_active_low sets pwm output polarity
// - ten-bit duty; zero never active, 0x3ff 1023 ticks
// - duty buffered, taken in after next underflow
// - buzzer on pin when enabled and configured; pwm routed and configured takes the pin first
// - buzzer_div_sel top bit picks source, rest divide
// - pwm on pin needs configuration option too
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module down_timer_pwm_buzzer #(
  parameter int prescale_width = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_clk,
  input wire logic pin_cfg_pwm,
  input wire logic pin_cfg_buzzer,
  output logic shared_out_pin,
  output logic shared_out_pin_oe,
  output logic irq_req
);

  // true when the low k+1 bits of v are all ones
  function automatic logic low_ones(input logic [7:0] v, input logic [2:0] k);
    logic [7:0] m;
    m = 8'hff >> (3'd7 - k);
    return (v & m) == m;
  endfunction

  function automatic logic mapped(input logic [5:0] a);
    return (a[1:0] == 2'b00) && (a <= down_timer_pkg::buzzer_ctrl_off);
  endfunction

  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] high_bits_q;
  logic [7:0] buzzer_ctrl_q;
  logic underflow_flag_q;
  logic underflow_irq_en_q;
  logic global_irq_en_q;
  logic [9:0] reload_buf_q;
  logic [9:0] duty_buf_q;
  logic [9:0] duty_act_q;
  logic [9:0] count_q;
  logic done_q;
  logic [prescale_width-1:0] prescale_q;
  logic ext_prev_q;
  logic [7:0] buzz_div_q;
  logic buzzer_wave_q;
  logic aw_have_q;
  logic w_have_q;
  logic [5:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;

  wire timer_run = ctrl_a_q[down_timer_pkg::timer_run_bit];
  wire reload_sel = ctrl_a_q[down_timer_pkg::reload_sel_bit];
  wire one_shot_sel = ctrl_a_q[down_timer_pkg::one_shot_sel_bit];
  wire pwm_active_low = ctrl_a_q[down_timer_pkg::pwm_active_low_bit];
  wire pwm_out_en = ctrl_a_q[down_timer_pkg::pwm_out_en_bit];
  wire count_src_sel = ctrl_b_q[down_timer_pkg::count_src_sel_bit];
  wire ext_edge_sel = ctrl_b_q[down_timer_pkg::ext_edge_sel_bit];
  wire prescale_enable_n = ctrl_b_q[down_timer_pkg::prescale_enable_n_bit];
  wire [2:0] prescale_ratio = ctrl_b_q[down_timer_pkg::prescale_ratio_lsb +: 3];
  wire buzzer_en = buzzer_ctrl_q[down_timer_pkg::buzzer_en_bit];
  wire [3:0] buzzer_div_sel = buzzer_ctrl_q[3:0];

  // a write happens once both address and data are held
  wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_en = wr_fire && wstrb0_q && mapped(awaddr_q);
  wire wr_ctrl_a = wr_en && (awaddr_q == down_timer_pkg::ctrl_a_off);
  wire wr_reload_low = wr_en && (awaddr_q == down_timer_pkg::reload_low_off);
  wire wr_duty_low = wr_en && (awaddr_q == down_timer_pkg::duty_low_off);
  wire wr_flag = wr_en && (awaddr_q == down_timer_pkg::irq_flag_off);

  // source tick: one per aclk, or the chosen pin edge
  wire ext_rise = ext_count_clk && !ext_prev_q;
  wire ext_fall = !ext_count_clk && ext_prev_q;
  wire ext_tick = ext_edge_sel ? ext_fall : ext_rise;
  wire src_tick = count_src_sel ? ext_tick : 1'b1;
  wire [7:0] prescale_low = 8'(prescale_q);
  wire prescale_tick = src_tick && low_ones(prescale_low, prescale_ratio);
  wire timer_tick = timer_run && !done_q && (prescale_enable_n ? src_tick : prescale_tick);
  wire underflow = timer_tick && (count_q == 10'h000);

  // edge detector reference; the pin is taken as synchronous
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_prev_q <= 1'b0;
    else
      ext_prev_q <= ext_count_clk;
  end

  // prescaler runs only while enabled and the timer runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prescale_q <= '0;
    else if (prescale_enable_n || !timer_run)
      prescale_q <= '0;
    else if (src_tick)
      prescale_q <= prescale_q + 1'b1;
  end

  // control registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_a_q <= down_timer_pkg::ctrl_a_rst;
      ctrl_b_q <= down_timer_pkg::ctrl_b_rst;
      high_bits_q <= 8'h00;
      buzzer_ctrl_q <= down_timer_pkg::buzzer_ctrl_rst;
      underflow_irq_en_q <= 1'b0;
      global_irq_en_q <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (awaddr_q)
        down_timer_pkg::ctrl_a_off: ctrl_a_q <= wdata_q;
        down_timer_pkg::ctrl_b_off: ctrl_b_q <= {2'b00, wdata_q[5:0]};
        down_timer_pkg::high_bits_off: high_bits_q <= {2'b00, wdata_q[5:4], 2'b00, wdata_q[1:0]};
        down_timer_pkg::buzzer_ctrl_off: buzzer_ctrl_q <= {wdata_q[7], 3'b000, wdata_q[3:0]};
        down_timer_pkg::irq_enable_off:
        begin
          underflow_irq_en_q <= wdata_q[down_timer_pkg::underflow_flag_bit];
          global_irq_en_q <= wdata_q[down_timer_pkg::global_irq_en_bit];
        end
        default: ;
      endcase
    end
  end

  // reload and duty buffers catch the high bits at the low byte write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reload_buf_q <= down_timer_pkg::count_rst;
      duty_buf_q <= 10'h000;
    end
    else
    begin
      if (wr_reload_low)
        reload_buf_q <= {high_bits_q[down_timer_pkg::reload_hi_lsb +: 2], wdata_q};
      if (wr_duty_low)
        duty_buf_q <= {high_bits_q[down_timer_pkg::duty_hi_lsb +: 2], wdata_q};
    end
  end

  // the comparator duty changes only at a frame boundary, so no glitch mid-frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      duty_act_q <= 10'h000;
    else if (underflow)
      duty_act_q <= duty_buf_q;
  end

  // down-counter with one-shot and continuous restart
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= down_timer_pkg::count_rst;
    else if (wr_reload_low && !timer_run)
      count_q <= {high_bits_q[down_timer_pkg::reload_hi_lsb +: 2], wdata_q};
    else if (underflow)
    begin
      if (one_shot_sel)
        count_q <= 10'h000;
      else if (reload_sel)
        count_q <= reload_buf_q;
      else
        count_q <= down_timer_pkg::count_max;
    end
    else if (timer_tick)
      count_q <= count_q - 10'h001;
  end

  // one-shot stop; a write to timer_ctrl_a or the reload rearms it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done_q <= 1'b0;
    else if (underflow && one_shot_sel)
      done_q <= 1'b1;
    else if (wr_ctrl_a || wr_reload_low)
      done_q <= 1'b0;
  end

  // sticky flag: a same-cycle underflow beats the software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      underflow_flag_q <= 1'b0;
    else if (underflow)
      underflow_flag_q <= 1'b1;
    else if (wr_flag && !wdata_q[down_timer_pkg::underflow_flag_bit])
      underflow_flag_q <= 1'b0;
  end

  assign irq_req = underflow_flag_q && underflow_irq_en_q && global_irq_en_q;

  // buzzer divider: source tick counted, output toggled every 2^n ticks
  wire buzz_src = buzzer_div_sel[down_timer_pkg::buzzer_src_bit] ? underflow :
                  (prescale_enable_n ? src_tick && timer_run : prescale_tick && timer_run);
  wire buzz_toggle = buzz_src && ((buzzer_div_sel[2:0] == 3'd0) ||
                     low_ones(buzz_div_q, 3'(buzzer_div_sel[2:0] - 3'd1)));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buzz_div_q <= 8'h00;
      buzzer_wave_q <= 1'b0;
    end
    else if (!buzzer_en)
    begin
      buzz_div_q <= 8'h00;
      buzzer_wave_q <= 1'b0;
    end
    else if (buzz_src)
    begin
      buzz_div_q <= buzz_div_q + 8'h01;
      if (buzz_toggle)
        buzzer_wave_q <= !buzzer_wave_q;
    end
  end

  // pwm active for the last duty counts of each frame
  wire pwm_active = count_q < duty_act_q;
  wire pwm_wave = pwm_active ^ pwm_active_low;

  // pin mux registered so the pad sees no decode glitches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shared_out_pin <= 1'b0;
      shared_out_pin_oe <= 1'b0;
    end
    else
    begin
      shared_out_pin_oe <= pwm_out_en || buzzer_en;
      if (pwm_out_en && pin_cfg_pwm)
        shared_out_pin <= pwm_wave;
      else if (buzzer_en && pin_cfg_buzzer)
        shared_out_pin <= buzzer_wave_q;
      else
        shared_out_pin <= 1'b0;
    end
  end

  // axi write channels: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= down_timer_pkg::resp_okay;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awaddr_q) ? down_timer_pkg::resp_okay : down_timer_pkg::resp_slverr;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read mux; write-only duty and high bits read back their stored values
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (s_axi_araddr)
      down_timer_pkg::ctrl_a_off: rd_byte = ctrl_a_q;
      down_timer_pkg::ctrl_b_off: rd_byte = ctrl_b_q;
      down_timer_pkg::high_bits_off: rd_byte = high_bits_q;
      down_timer_pkg::duty_low_off: rd_byte = duty_buf_q[7:0];
      down_timer_pkg::prescale_view_off: rd_byte = prescale_low;
      down_timer_pkg::irq_flag_off: rd_byte = {4'h0, underflow_flag_q, 3'b000};
      down_timer_pkg::irq_enable_off: rd_byte = {global_irq_en_q, 3'b000, underflow_irq_en_q, 3'b000};
      down_timer_pkg::buzzer_ctrl_off: rd_byte = buzzer_ctrl_q;
      default: rd_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= down_timer_pkg::resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == down_timer_pkg::reload_low_off)
        s_axi_rdata <= {22'h000000, count_q};
      else
        s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= mapped(s_axi_araddr) ? down_timer_pkg::resp_okay : down_timer_pkg::resp_slverr;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // down_timer_pwm_buzzer

// ==== down_timer_pwm_buzzer_assertions.sv ====
module down_timer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // address and data taken together at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // the held flags register first, so the response shows two edges after the take
  a_write_resp: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_write_bad: assert property (wr_taken ##0 (s_axi_awaddr > 6'h20) |->
    ##2 s_axi_bresp == down_timer_pkg::resp_slverr)
    else $error("unmapped write not refused");
  a_write_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_resp: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_read_bad: assert property (rd_taken ##0 (s_axi_araddr > 6'h20) |=>
    s_axi_rresp == down_timer_pkg::resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  // only a register write may drop the request
  a_flag_sticky: assert property ($fell(irq_req) |-> s_axi_bvalid)
    else $error("request dropped without a write");
endmodule // down_timer_checker

// ==== pin_partner.sv ====
module pin_partner (
  input wire logic aclk,
  output logic ext_count_clk,
  input wire logic shared_out_pin,
  input wire logic shared_out_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ext_count_clk = 1'b0;
  // slow edges well below aclk so the edge detector never misses one; idle between bursts
  task automatic toggle(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      ext_count_clk <= ~ext_count_clk;
      repeat (4) @(posedge aclk);
    end
  endtask
  // counts high cycles and level changes over a window, after the registered pin settles
  task automatic measure(input int n, output int hi, output int tr, output logic oe);
    logic last;
    hi = 0;
    tr = 0;
    repeat (2) @(posedge aclk);
    last = shared_out_pin;
    oe = shared_out_pin_oe;
    repeat (n)
    begin
      @(posedge aclk);
      hi += int'(shared_out_pin === 1'b1);
      tr += int'(shared_out_pin !== last);
      last = shared_out_pin;
    end
  endtask
endmodule // pin_partner

// ==== down_timer_pwm_buzzer_tb_top.sv ====
module down_timer_pwm_buzzer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_count_clk, pin_cfg_pwm, pin_cfg_buzzer;
  logic shared_out_pin, shared_out_pin_oe, irq_req, oe;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  logic [65:0] ent;
  int miscompares, n_compared, seed, hi, tr;
  down_timer_pwm_buzzer down_timer_pwm_buzzer_i (.*);
  pin_partner pin_partner_i (.*);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // master holds each channel until its ready, bready until the answer
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = down_timer_pkg::resp_okay);
    bq.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
                    input logic [1:0] er = down_timer_pkg::resp_okay);
    rq.push_back({er, m, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic meas;
    pin_partner_i.measure(60, hi, tr, oe);
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  // oldest note against each response as it is handed over
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready)
    begin
      ent = rq.pop_front();
      chk("rresp", {30'h0, ent[65:64]}, {30'h0, s_axi_rresp});
      chk("rdata", ent[31:0], s_axi_rdata & ent[63:32]);
    end
  end
  initial
  begin
    #200000;
    miscompares++;
    final_report;
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pin_cfg_pwm, pin_cfg_buzzer} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    aresetn = 1'b0;
    seed = 32'h6352c0b9;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(down_timer_pkg::ctrl_a_off, 32'h0);
    rd(down_timer_pkg::ctrl_b_off, 32'h08);
    rd(down_timer_pkg::reload_low_off, 32'h3ff);
    rd(6'h24, 32'h0, 32'hffffffff, down_timer_pkg::resp_slverr);
    wr(6'h24, 8'hff, down_timer_pkg::resp_slverr);
    done("reset");
    rv = $random(seed);
    wr(down_timer_pkg::high_bits_off, 8'h10);
    wr(down_timer_pkg::reload_low_off, rv[7:0]);
    rd(down_timer_pkg::reload_low_off, {22'h0, 2'b01, rv[7:0]});
    wr(down_timer_pkg::high_bits_off, 8'h00);
    wr(down_timer_pkg::reload_low_off, 8'h05);
    wr(down_timer_pkg::irq_enable_off, 8'h88);
    wr(down_timer_pkg::ctrl_a_off, 8'h05);
    repeat (20) @(posedge aclk);
    rd(down_timer_pkg::reload_low_off, 32'h0);
    rd(down_timer_pkg::irq_flag_off, 32'h08);
    chk("irq", 32'h1, {31'h0, irq_req});
    wr(down_timer_pkg::irq_enable_off, 8'h08);
    chk("irq", 32'h0, {31'h0, irq_req});
    wr(down_timer_pkg::irq_enable_off, 8'h88);
    wr(down_timer_pkg::irq_flag_off, 8'h08);
    chk("irq", 32'h1, {31'h0, irq_req});
    wr(down_timer_pkg::irq_flag_off, 8'h00);
    chk("irq", 32'h0, {31'h0, irq_req});
    done("one_shot");
    // restart from full scale, then from the stored reload
    wr(down_timer_pkg::ctrl_a_off, 8'h01);
    repeat (20) @(posedge aclk);
    wr(down_timer_pkg::ctrl_a_off, 8'h00);
    rd(down_timer_pkg::reload_low_off, 32'h3e0, 32'h3e0);
    // short reload so the count wraps several times within the run window
    wr(down_timer_pkg::reload_low_off, 8'h05);
    wr(down_timer_pkg::ctrl_a_off, 8'h03);
    repeat (20) @(posedge aclk);
    wr(down_timer_pkg::ctrl_a_off, 8'h02);
    rd(down_timer_pkg::reload_low_off, 32'h0, 32'h3f8);
    done("continuous");
    pin_cfg_pwm <= 1'b1;
    wr(down_timer_pkg::ctrl_a_off, 8'h83);
    meas;
    chk("pwm_high", 32'd0, hi);
    chk("pwm_oe", 32'h1, {31'h0, oe});
    wr(down_timer_pkg::ctrl_a_off, 8'hc3);
    meas;
    chk("pwm_high", 32'd60, hi);
    wr(down_timer_pkg::high_bits_off, 8'h00);
    wr(down_timer_pkg::duty_low_off, 8'h03);
    wr(down_timer_pkg::ctrl_a_off, 8'h83);
    repeat (10) @(posedge aclk);
    meas;
    chk("pwm_high", 32'd30, hi);
    pin_cfg_pwm <= 1'b0;
    meas;
    chk("pin_changes", 32'd0, tr);
    done("pwm");
    // edges from the partner; a trailing edge while stopped must not count
    wr(down_timer_pkg::ctrl_a_off, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(down_timer_pkg::ctrl_b_off, 8'(8'h28 | (i << 4)));
      wr(down_timer_pkg::reload_low_off, 8'h40);
      wr(down_timer_pkg::ctrl_a_off, 8'h03);
      pin_partner_i.toggle(3);
      wr(down_timer_pkg::ctrl_a_off, 8'h00);
      pin_partner_i.toggle(1);
      rd(down_timer_pkg::reload_low_off, 32'h3e + i);
    end
    done("ext_clock");
    pin_cfg_buzzer <= 1'b1;
    wr(down_timer_pkg::ctrl_b_off, 8'h08);
    wr(down_timer_pkg::reload_low_off, 8'h05);
    wr(down_timer_pkg::ctrl_a_off, 8'h03);
    for (int i = 0; i < 2; i++)
    begin
      wr(down_timer_pkg::buzzer_ctrl_off, 8'h88 | i);
      meas;
      chk("buzz_changes", 32'd10 >> i, tr);
      chk("buzz_oe", 32'h1, {31'h0, oe});
    end
    wr(down_timer_pkg::ctrl_b_off, 8'h00);
    wr(down_timer_pkg::buzzer_ctrl_off, 8'h80);
    meas;
    chk("buzz_changes", 32'd30, tr);
    done("buzzer");
    // pin edges through the prescaler at 1:4; stopping first clears the prescaler
    wr(down_timer_pkg::ctrl_a_off, 8'h00);
    wr(down_timer_pkg::ctrl_b_off, 8'h21);
    wr(down_timer_pkg::reload_low_off, 8'h10);
    wr(down_timer_pkg::ctrl_a_off, 8'h01);
    pin_partner_i.toggle(16);
    rd(down_timer_pkg::prescale_view_off, 32'h08);
    rd(down_timer_pkg::reload_low_off, 32'h0e);
    done("prescaler");
    final_report;
  end
endmodule // down_timer_pwm_buzzer_tb_top
bind down_timer_pwm_buzzer down_timer_checker down_timer_checker_i (.*);
